//--- rtl/sptc_map.svh
// register indices, field positions, reset values and counts
`ifndef SPTC_MAP_SVH
`define SPTC_MAP_SVH
// register indices; byte address is index times four
`define SPTC_IDX_SYNC 10'h00E
`define SPTC_IDX_CLAMP 10'h00F
`define SPTC_IDX_DELAY 10'h020
`define SPTC_IDX_WIDTH 10'h021
`define SPTC_IDX_CTRL 10'h022
`define SPTC_IDX_STAT 10'h023
// field positions
`define SPTC_LINE_POL_BIT 6
`define SPTC_EXT_CLAMP_BIT 7
`define SPTC_CLAMP_POL_BIT 6
`define SPTC_CHSEL_BIT 0
`define SPTC_YUV_BIT 1
`define SPTC_ST_CLAMP_BIT 0
`define SPTC_ST_LINE_BIT 1
`define SPTC_ST_GREEN_LSB 2
`define SPTC_ST_FRAME_LSB 4
// reset values
`define SPTC_LINE_POL_RST 1'h1
`define SPTC_EXT_CLAMP_RST 1'h0
`define SPTC_CLAMP_POL_RST 1'h1
`define SPTC_DELAY_RST 8'h08
`define SPTC_WIDTH_RST 8'h14
`define SPTC_CTRL_RST 2'h0
// green sync slicer: threshold in mV, sample step in mV
`define SPTC_SOG_THR_MV 150
`define SPTC_SOG_LSB_MV 4
`define SPTC_SOG_LEAK_LAST 10'h3FF
`endif

//--- rtl/sptc_pkg.sv
// shared types of the sync polarity and clamp timing block
package sptc_pkg;
  typedef enum {CLAMP_IDLE, CLAMP_DELAY, CLAMP_WINDOW} sptc_clamp_state_t;
  typedef logic [7:0] sptc_count_t;
endpackage

//--- rtl/sptc_sync_edge.sv
// line sync synchroniser with polarity-aware edge detection
`timescale 1ns/100ps
module sptc_sync_edge
  import sptc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // raw pin and its sense
  input wire logic syncPin,
  input wire logic activeHigh,
  // conditioned sync
  output logic syncActive,
  output logic leadEdge,
  output logic trailEdge
);
  logic meta;
  logic stable;
  logic prev;
  logic rising;
  logic falling;

  // two flops before any logic looks at the pin
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= syncPin;
      stable <= meta;
      prev <= stable;
    end
  end

  assign rising = stable & ~prev;
  assign falling = ~stable & prev;

  // sense picks which pin edge leads the line
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      leadEdge <= 1'b0;
      trailEdge <= 1'b0;
      syncActive <= 1'b0;
    end else begin
      leadEdge <= activeHigh ? rising : falling;
      trailEdge <= activeHigh ? falling : rising;
      syncActive <= (stable == activeHigh);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  lead_sense_a: assert property (
    (rising && activeHigh) || (falling && !activeHigh) |=> leadEdge)
    else $error("leading edge not taken from selected sense");
  trail_sense_a: assert property (
    (falling && activeHigh) || (rising && !activeHigh)
      |=> trailEdge && !leadEdge)
    else $error("trailing edge misclassified");
endmodule

//--- rtl/sptc_clamp_gen.sv
// clamp window: external pin or delay/duration counter
`timescale 1ns/100ps
module sptc_clamp_gen
  import sptc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // timing reference and settings
  input wire logic trailEdge,
  input wire sptc_count_t delay,
  input wire sptc_count_t width,
  // external clamp pin, already synchronised
  input wire logic extEnable,
  input wire logic extActiveHigh,
  input wire logic extLevel,
  // result
  output logic clampOn
);
  sptc_clamp_state_t state;
  sptc_count_t count;

  // counter restarts on every trailing edge, even mid-window
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= CLAMP_IDLE;
      count <= 8'h00;
    end else if (trailEdge) begin
      state <= CLAMP_DELAY;
      count <= delay;
    end else begin
      unique case (state)
        CLAMP_IDLE: begin
          count <= 8'h00;
        end
        CLAMP_DELAY: begin
          if (count == 8'h00) begin
            state <= (width == 8'h00) ? CLAMP_IDLE : CLAMP_WINDOW;
            count <= width;
          end else begin
            count <= count - 8'h01;
          end
        end
        CLAMP_WINDOW: begin
          if (count == 8'h01) begin
            state <= CLAMP_IDLE;
          end
          count <= count - 8'h01;
        end
      endcase
    end
  end

  // the pin is only looked at when software enables it
  assign clampOn = extEnable ? (extLevel == extActiveHigh)
                             : (state == CLAMP_WINDOW);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  delay_load_a: assert property (
    trailEdge |=> state == CLAMP_DELAY && count == $past(delay))
    else $error("delay not reloaded on trailing edge");
  delay_end_a: assert property (
    state == CLAMP_DELAY && count == 8'h00 && !trailEdge && width != 8'h00
      |=> state == CLAMP_WINDOW && count == $past(width))
    else $error("window did not follow delay");
  window_end_a: assert property (
    state == CLAMP_WINDOW && count == 8'h01 && !trailEdge
      |=> state == CLAMP_IDLE)
    else $error("window overran its duration");
  window_cov: cover property (
    trailEdge ##1 (state == CLAMP_DELAY) [*2] ##[1:300]
      (state == CLAMP_WINDOW));
endmodule

//--- rtl/sptc_top.sv
// sync polarity, green sync slicing and clamp timing with APB registers
// Notes on behaviour
// - line sync sense comes from register 0x0E bit 6
// - sense 0 makes falling edge active, sense 1 rising edge
// - clock generator reference is only the active leading edge
// - trailing edge is used only for clamp timing
// - green sync sliced 0.15 V above negative peak, output non-inverted
// - clamp pin honoured only while 0x0F bit 7 is set; resets 0
// - otherwise window counted as delay then duration from trailing edge
// - clamp pin active level set by 0x0F bit 6
// - during window clamp to ground for RGB, midscale for YUV
// - two independent sets of line, frame and green sync inputs
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "sptc_map.svh"
module sptc_top
  import sptc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // channel 0 sync inputs
  input wire logic line_sync_in_ch0,
  input wire logic frame_sync_in_ch0,
  input wire logic [7:0] green_sync_in_ch0,
  // channel 1 sync inputs
  input wire logic line_sync_in_ch1,
  input wire logic frame_sync_in_ch1,
  input wire logic [7:0] green_sync_in_ch1,
  // external clamp pin
  input wire logic clampPin,
  // sync outputs
  output logic pllRefEdge,
  output logic lineSyncActive,
  output logic frameSyncOut,
  output logic green_sync_out,
  // clamp outputs
  output logic clampGround,
  output logic clampMidscale
);
  localparam logic [8:0] SOG_THR =
    9'(`SPTC_SOG_THR_MV / `SPTC_SOG_LSB_MV);

  // configuration
  logic line_sync_polarity;
  logic extClampEn;
  logic clampPol;
  sptc_count_t clampDelay;
  sptc_count_t clampWidth;
  logic chSel;
  logic yuvMode;

  // bus decode
  logic [9:0] wordIdx;
  logic addrHit;
  logic [31:0] rdMux;
  logic setupPhase;
  logic wrStrobe;

  // per-channel sync state
  logic [1:0] linePins;
  logic [1:0] framePins;
  logic [7:0] greenSample [2];
  logic [1:0] leadE;
  logic [1:0] trailE;
  logic [1:0] lineAct;
  logic [1:0] frameMeta;
  logic [1:0] frameLvl;
  logic [1:0] sogCmp;
  logic [9:0] leakCnt;
  logic leakTick;

  // clamp path
  logic clampMeta;
  logic clampLevel;
  logic clampOn;

  assign linePins = {line_sync_in_ch1, line_sync_in_ch0};
  assign framePins = {frame_sync_in_ch1, frame_sync_in_ch0};
  assign greenSample[0] = green_sync_in_ch0;
  assign greenSample[1] = green_sync_in_ch1;

  // ---- register bus ----
  assign wordIdx = paddr[11:2];
  assign setupPhase = psel & ~penable;
  assign wrStrobe = psel & penable & pready & pwrite & addrHit;

  // address decode and read mux; misaligned addresses miss
  always_comb begin
    addrHit = (paddr[1:0] == 2'b00);
    rdMux = 32'h0000_0000;
    unique case (wordIdx)
      `SPTC_IDX_SYNC: begin
        rdMux[`SPTC_LINE_POL_BIT] = line_sync_polarity;
      end
      `SPTC_IDX_CLAMP: begin
        rdMux[`SPTC_EXT_CLAMP_BIT] = extClampEn;
        rdMux[`SPTC_CLAMP_POL_BIT] = clampPol;
      end
      `SPTC_IDX_DELAY: begin
        rdMux[7:0] = clampDelay;
      end
      `SPTC_IDX_WIDTH: begin
        rdMux[7:0] = clampWidth;
      end
      `SPTC_IDX_CTRL: begin
        rdMux[`SPTC_CHSEL_BIT] = chSel;
        rdMux[`SPTC_YUV_BIT] = yuvMode;
      end
      `SPTC_IDX_STAT: begin
        rdMux[`SPTC_ST_CLAMP_BIT] = clampOn;
        rdMux[`SPTC_ST_LINE_BIT] = lineAct[chSel];
        rdMux[`SPTC_ST_GREEN_LSB +: 2] = sogCmp;
        rdMux[`SPTC_ST_FRAME_LSB +: 2] = frameLvl;
      end
      default: begin
        addrHit = 1'b0;
      end
    endcase
  end

  // one answer cycle: ready rises for the access phase after setup
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setupPhase;
      if (setupPhase) begin
        pslverr <= ~addrHit;
        prdata <= pwrite ? 32'h0000_0000 : rdMux;
      end else if (pready) begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end

  // line sync sense
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      line_sync_polarity <= `SPTC_LINE_POL_RST;
    end else if (wrStrobe && wordIdx == `SPTC_IDX_SYNC) begin
      line_sync_polarity <= pwdata[`SPTC_LINE_POL_BIT];
    end
  end

  // external clamp enable and pin sense
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      extClampEn <= `SPTC_EXT_CLAMP_RST;
      clampPol <= `SPTC_CLAMP_POL_RST;
    end else if (wrStrobe && wordIdx == `SPTC_IDX_CLAMP) begin
      extClampEn <= pwdata[`SPTC_EXT_CLAMP_BIT];
      clampPol <= pwdata[`SPTC_CLAMP_POL_BIT];
    end
  end

  // internal window timing, in pixel clocks
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clampDelay <= `SPTC_DELAY_RST;
      clampWidth <= `SPTC_WIDTH_RST;
    end else if (wrStrobe) begin
      if (wordIdx == `SPTC_IDX_DELAY) begin
        clampDelay <= pwdata[7:0];
      end
      if (wordIdx == `SPTC_IDX_WIDTH) begin
        clampWidth <= pwdata[7:0];
      end
    end
  end

  // channel select and clamp reference
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {yuvMode, chSel} <= `SPTC_CTRL_RST;
    end else if (wrStrobe && wordIdx == `SPTC_IDX_CTRL) begin
      chSel <= pwdata[`SPTC_CHSEL_BIT];
      yuvMode <= pwdata[`SPTC_YUV_BIT];
    end
  end

  // ---- per-channel sync conditioning ----
  // slow leak lets the peak follow a source that gets brighter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      leakCnt <= 10'h000;
    end else begin
      leakCnt <= leakCnt + 10'h001;
    end
  end
  assign leakTick = (leakCnt == `SPTC_SOG_LEAK_LAST);

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [7:0] sogPeak;

    sptc_sync_edge u_line (
      .ref_clk(ref_clk),
      .rst(rst),
      .syncPin(linePins[ch]),
      .activeHigh(line_sync_polarity),
      .syncActive(lineAct[ch]),
      .leadEdge(leadE[ch]),
      .trailEdge(trailE[ch])
    );

    // frame sync only needs a clean level
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        frameMeta[ch] <= 1'b0;
        frameLvl[ch] <= 1'b0;
      end else begin
        frameMeta[ch] <= framePins[ch];
        frameLvl[ch] <= frameMeta[ch];
      end
    end

    // negative peak follows down at once, up only by the leak
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        sogPeak <= 8'hFF;
      end else if (greenSample[ch] < sogPeak) begin
        sogPeak <= greenSample[ch];
      end else if (leakTick && sogPeak != 8'hFF) begin
        sogPeak <= sogPeak + 8'h01;
      end
    end

    // high above the slice, low in the sync tip: not inverted
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        sogCmp[ch] <= 1'b1;
      end else begin
        sogCmp[ch] <= {1'b0, greenSample[ch]} >=
                      ({1'b0, sogPeak} + SOG_THR);
      end
    end
  end

  // ---- clamp pin ----
  // synchronised even when disabled so enabling it never sees metastability
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clampMeta <= 1'b0;
      clampLevel <= 1'b0;
    end else begin
      clampMeta <= clampPin;
      clampLevel <= clampMeta;
    end
  end

  // a floating pin is harmless only because the enable resets to 0
  sptc_clamp_gen u_clamp (
    .ref_clk(ref_clk),
    .rst(rst),
    .trailEdge(trailE[chSel]),
    .delay(clampDelay),
    .width(clampWidth),
    .extEnable(extClampEn),
    .extActiveHigh(clampPol),
    .extLevel(clampLevel),
    .clampOn(clampOn)
  );

  // ---- registered outputs ----
  // only the leading edge reaches the clock generator
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pllRefEdge <= 1'b0;
      lineSyncActive <= 1'b0;
      frameSyncOut <= 1'b0;
      green_sync_out <= 1'b1;
    end else begin
      pllRefEdge <= leadE[chSel];
      lineSyncActive <= lineAct[chSel];
      frameSyncOut <= frameLvl[chSel];
      green_sync_out <= sogCmp[chSel];
    end
  end

  // clamp target depends on the colour space of the source
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clampGround <= 1'b0;
      clampMidscale <= 1'b0;
    end else begin
      clampGround <= clampOn & ~yuvMode;
      clampMidscale <= clampOn & yuvMode;
    end
  end

  // ---- checks ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sense_write_a: assert property (
    wrStrobe && wordIdx == `SPTC_IDX_SYNC
      |=> line_sync_polarity == $past(pwdata[`SPTC_LINE_POL_BIT]))
    else $error("line sync sense not written");
  lead_only_a: assert property (
    pllRefEdge |-> $past(leadE[chSel]) && !$past(trailE[chSel]))
    else $error("reference edge not the leading edge");
  lead_follow_a: assert property (
    leadE[chSel] && $stable(chSel) |=> pllRefEdge)
    else $error("leading edge lost");
  green_slice_a: assert property (
    $stable(chSel) |=> green_sync_out == $past(sogCmp[chSel]))
    else $error("green sync output wrong");
  ext_clamp_a: assert property (
    extClampEn && $stable(extClampEn) && $stable(clampPol)
      ##1 extClampEn
      |-> (clampGround | clampMidscale) ==
          ($past(clampLevel) == $past(clampPol)))
    else $error("external clamp not followed");
  pin_ignored_a: assert property (
    !extClampEn |=> (clampGround | clampMidscale) ==
      $past(u_clamp.state == CLAMP_WINDOW))
    else $error("clamp pin acted while disabled");
  clamp_target_a: assert property (
    !(clampGround && clampMidscale)
      and (clampMidscale |-> $past(yuvMode)))
    else $error("clamp target wrong");
  frame_select_a: assert property (
    $stable(chSel) |=> frameSyncOut == $past(frameLvl[chSel]))
    else $error("frame sync from wrong channel");
  apb_answer_a: assert property (
    setupPhase |=> pready ##1 !pready)
    else $error("apb answer not one cycle");

  ch1_edge_cov: cover property (chSel && leadE[1] ##1 pllRefEdge);
  ext_window_cov: cover property (extClampEn && clampGround [*3]);
  yuv_clamp_cov: cover property (clampMidscale);
  bad_addr_cov: cover property (pready && pslverr);
endmodule

//--- bench/sptc_source.sv
// video source model: line, frame and green sync plus clamp pin
`timescale 1ns/100ps
module sptc_source (
  // clock
  input wire logic ref_clk,
  // sync pins of both channels
  output logic line_sync_in_ch0,
  output logic line_sync_in_ch1,
  output logic frame_sync_in_ch0,
  output logic frame_sync_in_ch1,
  output logic [7:0] green_sync_in_ch0,
  output logic [7:0] green_sync_in_ch1,
  // external clamp pin
  output logic clampPin
);
  logic clampUse;
  logic clampAct;
  // quiet pins at start; unused clamp pin sits low
  initial begin
    line_sync_in_ch0 = 1'b0;
    line_sync_in_ch1 = 1'b0;
    frame_sync_in_ch0 = 1'b0;
    frame_sync_in_ch1 = 1'b0;
    green_sync_in_ch0 = 8'h00;
    green_sync_in_ch1 = 8'h00;
    clampPin = 1'b0;
    clampUse = 1'b0;
    clampAct = 1'b1;
  end
  // park a line sync pin at a level
  task automatic idle(input int ch, input logic v);
    @(posedge ref_clk);
    if (ch == 0) line_sync_in_ch0 <= v;
    else line_sync_in_ch1 <= v;
  endtask
  // one sync pulse; the clamp pin follows only in the back porch
  task automatic line_pulse(input int ch, input logic act, input int w);
    idle(ch, act);
    repeat (w - 1) @(posedge ref_clk);
    idle(ch, !act);
    if (clampUse) begin
      clampPin <= clampAct;
      repeat (4) @(posedge ref_clk);
      clampPin <= !clampAct;
    end
  endtask
  // choose clamp pin use; when unused it is grounded
  task automatic set_clamp(input logic use_it, input logic act);
    @(posedge ref_clk);
    clampUse <= use_it;
    clampAct <= act;
    clampPin <= use_it ? !act : 1'b0;
  endtask
  // raw clamp pin level
  task automatic pin(input logic v);
    @(posedge ref_clk);
    clampPin <= v;
  endtask
  // frame sync and green level of one channel
  task automatic levels(input int ch, input logic f, input logic [7:0] g);
    @(posedge ref_clk);
    if (ch == 0) begin
      frame_sync_in_ch0 <= f;
      green_sync_in_ch0 <= g;
    end else begin
      frame_sync_in_ch1 <= f;
      green_sync_in_ch1 <= g;
    end
  endtask
endmodule

//--- bench/tb_top.sv
// self-checking bench of the sync polarity and clamp timing block
`timescale 1ns/100ps
`include "sptc_map.svh"
module tb_top;
  import sptc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, pllRefEdge, lineSyncActive, frameSyncOut;
  logic green_sync_out, clampGround, clampMidscale, clampPin;
  logic line0, line1, frame0, frame1;
  logic [7:0] green0, green1;
  int n_fail = 0;
  int checks_done = 0;
  int firstRef, nRef, firstClamp, nGnd, nMid, nAct;
  logic [31:0] rd;
  logic err;
  localparam logic [11:0] A_SYNC = {`SPTC_IDX_SYNC, 2'b00};
  localparam logic [11:0] A_CLAMP = {`SPTC_IDX_CLAMP, 2'b00};
  localparam logic [11:0] A_DELAY = {`SPTC_IDX_DELAY, 2'b00};
  localparam logic [11:0] A_WIDTH = {`SPTC_IDX_WIDTH, 2'b00};
  localparam logic [11:0] A_CTRL = {`SPTC_IDX_CTRL, 2'b00};

  always #10 ref_clk = ~ref_clk;

  sptc_top DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_sync_in_ch0(line0), .frame_sync_in_ch0(frame0),
    .green_sync_in_ch0(green0), .line_sync_in_ch1(line1),
    .frame_sync_in_ch1(frame1), .green_sync_in_ch1(green1),
    .clampPin(clampPin), .pllRefEdge(pllRefEdge),
    .lineSyncActive(lineSyncActive), .frameSyncOut(frameSyncOut),
    .green_sync_out(green_sync_out), .clampGround(clampGround),
    .clampMidscale(clampMidscale));

  sptc_source SRC (.ref_clk(ref_clk), .line_sync_in_ch0(line0),
    .line_sync_in_ch1(line1), .frame_sync_in_ch0(frame0),
    .frame_sync_in_ch1(frame1), .green_sync_in_ch0(green0),
    .green_sync_in_ch1(green1), .clampPin(clampPin));

  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // compare one value
  task automatic chk(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      chk(0, 1, "apb timeout");
      results();
    end
  endtask
  // count reference pulses and clamp cycles over n edges
  task automatic watch(input int n);
    nRef = 0;
    nGnd = 0;
    nMid = 0;
    nAct = 0;
    firstRef = -1;
    firstClamp = -1;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      if (pllRefEdge === 1'b1 && nRef++ == 0) firstRef = i;
      if ((clampGround | clampMidscale) === 1'b1 && firstClamp < 0)
        firstClamp = i;
      if (clampGround === 1'b1) nGnd++;
      if (clampMidscale === 1'b1) nMid++;
      if (lineSyncActive === 1'b1) nAct++;
    end
  endtask
  // reset values and an unmapped place
  task automatic t_reset();
    apb(0, A_SYNC, 0);
    chk(rd, 32'h0000_0040, "sense reset");
    apb(0, A_CLAMP, 0);
    chk(rd, 32'h0000_0040, "clamp reset");
    apb(0, A_DELAY, 0);
    chk(rd, 32'h0000_0008, "delay reset");
    apb(0, A_WIDTH, 0);
    chk(rd, 32'h0000_0014, "width reset");
    apb(0, 12'h0FC, 0);
    chk({rd[30:0], err}, 32'h0000_0001, "unmapped read");
  endtask
  // each sense: one reference pulse, on the active edge only
  task automatic t_polarity();
    for (int s = 1; s >= 0; s--) begin
      apb(1, A_SYNC, s << 6);
      SRC.idle(0, !s[0]);
      repeat (30) @(posedge ref_clk);
      fork
        SRC.line_pulse(0, s[0], 10);
        watch(30);
      join
      chk(nRef, 1, "one ref pulse");
      chk(firstRef, 5, "active edge");
      chk(nAct, 10, "active level width");
    end
  endtask
  // internal window, clamp pin toggling but ignored, rgb and yuv
  task automatic t_internal();
    int yuv[3] = '{0, 1, 0};
    int wd[3] = '{3, 3, 0};
    SRC.set_clamp(1, 1);
    apb(1, A_DELAY, 2);
    // let the long window left from the polarity pulses run out first
    repeat (40) @(posedge ref_clk);
    for (int k = 0; k < 3; k++) begin
      apb(1, A_WIDTH, wd[k]);
      apb(1, A_CTRL, yuv[k] << 1);
      fork
        SRC.line_pulse(0, 0, 6);
        watch(40);
      join
      if (wd[k] > 0) chk(firstClamp, 15, "window start");
      chk(nGnd, yuv[k] ? 0 : wd[k], "ground cycles");
      chk(nMid, yuv[k] ? wd[k] : 0, "midscale cycles");
    end
  endtask
  // external pin with both senses, three edges of latency
  task automatic t_external();
    for (int p = 1; p >= 0; p--) begin
      apb(1, A_CLAMP, 32'h0000_0080 | (p << 6));
      SRC.set_clamp(1, p[0]);
      repeat (6) @(posedge ref_clk);
      chk(clampGround, 0, "pin idle");
      SRC.pin(p[0]);
      repeat (3) @(posedge ref_clk);
      chk(clampGround, 0, "pin early");
      @(posedge ref_clk);
      chk(clampGround, 1, "pin honoured");
      SRC.pin(!p[0]);
    end
    apb(1, A_CLAMP, 32'h0000_0040);
    SRC.set_clamp(0, 1);
  endtask
  // channel 1 selected: its sync, frame and green only
  task automatic t_channel();
    SRC.idle(1, 1'b1);
    apb(1, A_CTRL, 1);
    repeat (10) @(posedge ref_clk);
    fork
      SRC.line_pulse(0, 0, 6);
      watch(20);
    join
    chk(nRef, 0, "other channel");
    fork
      SRC.line_pulse(1, 0, 6);
      watch(20);
    join
    chk(nRef, 1, "selected channel");
    SRC.levels(0, 0, 8'h25);
    SRC.levels(1, 1, 8'h00);
    repeat (6) @(posedge ref_clk);
    chk(frameSyncOut, 1, "frame sync");
    chk(green_sync_out, 0, "green tip");
    SRC.levels(1, 0, 8'h24);
    repeat (4) @(posedge ref_clk);
    chk(green_sync_out, 0, "below threshold");
    chk(frameSyncOut, 0, "frame sync low");
    SRC.levels(1, 0, 8'h00);
    SRC.levels(1, 0, 8'h25);
    repeat (4) @(posedge ref_clk);
    chk(green_sync_out, 1, "at threshold");
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_reset();
    t_polarity();
    t_internal();
    t_external();
    t_channel();
    results();
  end
endmodule
